// ### src/dcp_pkg.sv
// Functional notes
// - Dual-address cycle steal: ignore requests until last peripheral-side transfer starts; code ignores them only for operands of more than one part.
// - Select code 11: first request internal at start, later ones external.
// - Mixed request mode keeps acknowledge and control line per configured protocol.
// - Type field: 00/01 dual-address protocols, 10/11 single-address protocols.
// - Dual-address: read source into holding store, then write destination separately.
// - Asynchronous peripheral: take bus per request, use normal strobe/acknowledge cycles.
// - E-clock peripheral: control line is enable clock, acknowledge is valid memory address.
// - E-clock read data captured on enable falling edge; outside latch holds it.
// - Single-address: select by acknowledge, address memory only, one cycle, bypass store.
// - Acknowledge-only: get bus, assert acknowledge, drive all memory control signals.
// - Memory acknowledge during acknowledge-only transfer asserts the complete strobe.
// - Peripheral-to-memory: data strobes follow acknowledge by one bus clock.
// - Master indicator on half clock before controls; controls float half clock before it.
// - Single-address: buffer direction and buffer enable stay inactive.
// - Single-address cycle lasts at least four clocks (read) or five (write).
// - Eight-bit port single-address: only one byte strobe per cycle.
// - Low address bits valid one and a half clocks at cycle start.
// - Auto or external requests chosen by the request generation select field.
package dcp_pkg;
  localparam int unsigned CLOCK_MHZ   = 250;
  localparam int unsigned BUS_HALF_NS = 8;
  localparam int unsigned HALF_CYCLES = (BUS_HALF_NS * CLOCK_MHZ + 999) / 1000;
  localparam logic [1:0] REQUEST_GENERATION_SELECT_AUTO_LIMITED = 2'h0;
  localparam logic [1:0] REQUEST_GENERATION_SELECT_AUTO_MAX     = 2'h1;
  localparam logic [1:0] REQUEST_GENERATION_SELECT_EXTERNAL     = 2'h2;
  localparam logic [1:0] REQUEST_GENERATION_SELECT_MIXED        = 2'h3;
  localparam logic [1:0] PTYPE_ASYNC   = 2'h0;
  localparam logic [1:0] PTYPE_ECLOCK  = 2'h1;
  localparam logic [1:0] PTYPE_ACK     = 2'h2;
  localparam logic [1:0] PTYPE_ACK_RDY = 2'h3;
  localparam logic [4:0] MIN_HALVES_DUAL  = 5'h08;
  localparam logic [4:0] MIN_HALVES_SA_RD = 5'h08;
  localparam logic [4:0] MIN_HALVES_SA_WR = 5'h0a;
  localparam logic [4:0] WR_STROBE_HALVES = 5'h02;
  localparam logic [4:0] ADDR_LOW_HALVES  = 5'h03;
  localparam int unsigned DATA_WIDTH = 16;
  localparam int unsigned BUF_DEPTH  = 2;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ARB, ST_OWN, ST_CYC, ST_TERM, ST_REL, ST_DROP
  } dcp_state_e;
endpackage

// ### src/dcp_buf2.sv
`timescale 1ns/10ps
`default_nettype none
module dcp_buf2
  import dcp_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire logic [DATA_WIDTH-1:0] in_data,
  input  wire logic                  in_valid,
  output logic                       in_ready,
  output logic [DATA_WIDTH-1:0]      out_data,
  output logic                       out_valid,
  input  wire logic                  out_ready
);
  logic [DATA_WIDTH-1:0] slot [BUF_DEPTH];
  logic                  wr_ptr;
  logic                  rd_ptr;
  logic [1:0]            count;
  wire                   push = in_valid & in_ready;
  wire                   pop  = out_valid & out_ready;

  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data  = slot[rd_ptr];

  genvar i;
  generate
    for (i = 0; i < BUF_DEPTH; i++) begin : g_slot
      always_ff @(posedge clock) begin
        if (push && wr_ptr == i[0]) begin
          slot[i] <= in_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (reset) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) wr_ptr <= ~wr_ptr;
      if (pop) rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // dcp_buf2
`default_nettype wire

// ### src/dcp_channel.sv
`timescale 1ns/10ps
`default_nettype none
module dcp_channel
  import dcp_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire logic                  channel_enable,
  input  wire logic [1:0]            request_generation_select,
  input  wire logic [1:0]            peripheral_type_field,
  input  wire logic                  to_peripheral,
  input  wire logic                  port_is_8bit,
  input  wire logic                  byte_odd,
  input  wire logic [1:0]            operand_parts,
  input  wire logic                  request_n,
  input  wire logic                  peripheral_control_line,
  input  wire logic                  bus_grant,
  input  wire logic                  dtack_n,
  input  wire logic [DATA_WIDTH-1:0] data_in,
  output logic                       bus_request,
  output logic                       bus_master_oe,
  output logic                       control_oe,
  output logic                       as_n,
  output logic                       uds_n,
  output logic                       lds_n,
  output logic                       rw_n,
  output logic                       address_is_peripheral,
  output logic                       addr_low_valid,
  output logic                       ack_n,
  output logic                       transfer_complete_strobe_n,
  output logic                       data_buffer_direction,
  output logic                       data_buffer_enable_n,
  output logic [DATA_WIDTH-1:0]      data_out,
  output logic                       data_oe,
  output logic                       operand_done
);
  dcp_state_e state;
  logic [1:0] div_cnt;
  logic       tick;
  logic       enable_q;
  logic       request_q;
  logic       pcl_q;
  logic       pending;
  logic       ignore_req;
  logic       phase_write;
  logic [1:0] parts_left;
  logic [4:0] half_cnt;
  logic       strobes_on;
  logic       done_seen;
  logic       vma_on;
  logic       e_rose;
  logic       single_cyc;
  logic       eclock_cyc;
  logic       dual_mode;

  wire single_mode = peripheral_type_field[1];
  wire start_pulse = channel_enable & ~enable_q;
  wire req_fall    = request_q & ~request_n;
  wire e_fall      = pcl_q & ~peripheral_control_line;
  wire e_rise      = ~pcl_q & peripheral_control_line;
  wire auto_req    = (request_generation_select == REQUEST_GENERATION_SELECT_AUTO_MAX) |
                     (request_generation_select == REQUEST_GENERATION_SELECT_AUTO_LIMITED);
  wire ext_req     = (request_generation_select == REQUEST_GENERATION_SELECT_EXTERNAL) |
                     (request_generation_select == REQUEST_GENERATION_SELECT_MIXED);
  // Peripheral side: source on reads, destination on writes
  wire periph_side = dual_mode & (to_peripheral ? phase_write : ~phase_write);
  wire cyc_write   = dual_mode ? phase_write : ~to_peripheral;
  wire [4:0] min_halves = single_cyc ? (cyc_write ? MIN_HALVES_SA_WR : MIN_HALVES_SA_RD)
                                     : MIN_HALVES_DUAL;
  wire [4:0] ds_delay   = cyc_write ? WR_STROBE_HALVES : 5'h00;
  wire take        = (state == ST_IDLE) & channel_enable & (pending | auto_req);
  wire buf_in_ready;
  wire buf_out_valid;
  wire [DATA_WIDTH-1:0] buf_out_data;
  // Back-pressure: a read waits for room, a write waits for a held word
  wire can_start   = single_mode | (phase_write ? buf_out_valid : buf_in_ready);
  wire cyc_end     = (state == ST_CYC) & tick & done_seen & (half_cnt + 5'h01 >= min_halves);
  wire push        = cyc_end & dual_mode & ~phase_write;
  wire pop         = cyc_end & dual_mode & phase_write;
  wire last_part   = (parts_left == 2'h1);
  wire more_cycles = dual_mode & ~(phase_write & last_part);
  wire own_done    = (state == ST_OWN) & tick & can_start;
  wire periph_last_start = own_done & periph_side & last_part;

  dcp_buf2 i_dcp_buf2 (
    .clock     (clock),
    .reset     (reset),
    .in_data   (data_in),
    .in_valid  (push),
    .in_ready  (buf_in_ready),
    .out_data  (buf_out_data),
    .out_valid (buf_out_valid),
    .out_ready (pop)
  );

  assign bus_request  = (state == ST_ARB);
  assign operand_done = cyc_end & ~more_cycles;

  always_ff @(posedge clock) begin
    if (reset) begin
      div_cnt   <= 2'h0;
      tick      <= 1'b0;
      enable_q  <= 1'b0;
      request_q <= 1'b1;
      pcl_q     <= 1'b0;
    end else begin
      div_cnt   <= (div_cnt == 2'(HALF_CYCLES - 1)) ? 2'h0 : div_cnt + 2'h1;
      tick      <= (div_cnt == 2'(HALF_CYCLES - 1));
      enable_q  <= channel_enable;
      request_q <= request_n;
      pcl_q     <= peripheral_control_line;
    end
  end

  // Mixed: internal first request
  // Set wins over the clear so a request on the take cycle survives
  always_ff @(posedge clock) begin
    if (reset) begin
      pending    <= 1'b0;
      ignore_req <= 1'b0;
    end else begin
      pending <= (pending & ~take & channel_enable) |
                 (start_pulse & (request_generation_select == REQUEST_GENERATION_SELECT_MIXED)) |
                 (req_fall & ext_req & ~ignore_req & channel_enable);
      if (periph_last_start) begin
        ignore_req <= 1'b0;
      end else if (take & ~single_mode & operand_parts > 2'h1) begin
        ignore_req <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state       <= ST_IDLE;
      phase_write <= 1'b0;
      parts_left  <= 2'h0;
      dual_mode   <= 1'b0;
      single_cyc  <= 1'b0;
      eclock_cyc  <= 1'b0;
      half_cnt    <= 5'h00;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (take) begin
            dual_mode   <= ~single_mode;
            single_cyc  <= single_mode;
            phase_write <= 1'b0;
            parts_left  <= single_mode ? 2'h1 : operand_parts;
            state       <= ST_ARB;
          end
        end
        ST_ARB: if (bus_grant) state <= ST_OWN;
        ST_OWN: begin
          if (own_done) begin
            eclock_cyc <= periph_side & (peripheral_type_field == PTYPE_ECLOCK);
            half_cnt   <= 5'h00;
            state      <= ST_CYC;
          end
        end
        ST_CYC: begin
          if (tick) half_cnt <= half_cnt + 5'h01;
          if (cyc_end) state <= ST_TERM;
        end
        ST_TERM: begin
          if (tick) begin
            if (more_cycles) begin
              if (phase_write) parts_left <= parts_left - 2'h1;
              phase_write <= ~phase_write;
              state       <= ST_OWN;
            end else begin
              state <= ST_REL;
            end
          end
        end
        ST_REL: if (tick) state <= ST_DROP;
        ST_DROP: if (tick) state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Bus cycle strobes and peripheral handshake
  always_ff @(posedge clock) begin
    if (reset) begin
      bus_master_oe <= 1'b0;
      control_oe    <= 1'b0;
      as_n          <= 1'b1;
      uds_n         <= 1'b1;
      lds_n         <= 1'b1;
      rw_n          <= 1'b1;
      strobes_on    <= 1'b0;
      done_seen     <= 1'b0;
      vma_on        <= 1'b0;
      e_rose        <= 1'b0;
      ack_n         <= 1'b1;
      addr_low_valid             <= 1'b0;
      transfer_complete_strobe_n <= 1'b1;
      address_is_peripheral      <= 1'b0;
      data_buffer_direction      <= 1'b0;
      data_buffer_enable_n       <= 1'b1;
      data_out      <= '0;
      data_oe       <= 1'b0;
    end else begin
      if (state == ST_ARB && bus_grant) bus_master_oe <= 1'b1;
      if (state == ST_DROP && tick) bus_master_oe <= 1'b0;
      if (own_done) begin
        control_oe     <= 1'b1;
        as_n           <= 1'b0;
        rw_n           <= ~cyc_write;
        addr_low_valid <= 1'b1;
        done_seen      <= 1'b0;
        vma_on         <= 1'b0;
        e_rose         <= 1'b0;
        strobes_on     <= 1'b0;
        address_is_peripheral <= periph_side;
        data_buffer_direction <= periph_side & ~cyc_write;
        data_buffer_enable_n  <= ~periph_side;
        if (single_mode) ack_n <= 1'b0;
        if (pop | (phase_write & dual_mode)) data_out <= buf_out_data;
        data_oe <= dual_mode & phase_write;
      end
      if (state == ST_CYC && tick && half_cnt + 5'h01 == ADDR_LOW_HALVES) addr_low_valid <= 1'b0;
      if (state == ST_CYC && !strobes_on && (half_cnt >= ds_delay)) begin
        strobes_on <= 1'b1;
        uds_n <= port_is_8bit & single_cyc & ~byte_odd;
        lds_n <= port_is_8bit & single_cyc & byte_odd;
      end
      if (state == ST_CYC && eclock_cyc && strobes_on && !done_seen) begin
        if (!vma_on && !peripheral_control_line) begin
          vma_on <= 1'b1;
          ack_n  <= 1'b0;
        end
        if (vma_on && e_rise) e_rose <= 1'b1;
        if (vma_on && e_rose && e_fall) done_seen <= 1'b1;
      end
      if (state == ST_CYC && !eclock_cyc && strobes_on && !dtack_n && !done_seen) begin
        done_seen <= 1'b1;
        if (single_cyc) transfer_complete_strobe_n <= 1'b0;
      end
      if (cyc_end) begin
        as_n       <= 1'b1;
        uds_n      <= 1'b1;
        lds_n      <= 1'b1;
        strobes_on <= 1'b0;
        ack_n      <= 1'b1;
        transfer_complete_strobe_n <= 1'b1;
        data_buffer_enable_n       <= 1'b1;
      end
      // Controls float before the indicator drops
      if (state == ST_REL && tick) begin
        control_oe            <= 1'b0;
        data_oe               <= 1'b0;
        rw_n                  <= 1'b1;
        address_is_peripheral <= 1'b0;
        data_buffer_direction <= 1'b0;
      end
    end
  end
endmodule // dcp_channel
`default_nettype wire

// ### tb/dcp_channel_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module dcp_channel_assertions
  import dcp_pkg::*;
(
  input wire logic       clock,
  input wire logic       reset,
  input wire logic [1:0] peripheral_type_field,
  input wire logic       to_peripheral,
  input wire logic       port_is_8bit,
  input wire logic       byte_odd,
  input wire logic       dtack_n,
  input wire logic       bus_master_oe,
  input wire logic       control_oe,
  input wire logic       as_n,
  input wire logic       uds_n,
  input wire logic       lds_n,
  input wire logic       address_is_peripheral,
  input wire logic       addr_low_valid,
  input wire logic       ack_n,
  input wire logic       transfer_complete_strobe_n,
  input wire logic       data_buffer_enable_n,
  input wire logic       operand_done
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic [5:0] low_cnt;
  wire        single = peripheral_type_field[1];
  wire        ds_off = uds_n && lds_n;
  // Saturates so a stuck strobe cannot wrap into a short count
  always_ff @(posedge clock) begin
    if (reset || as_n) begin
      low_cnt <= 6'h00;
    end else if (low_cnt != 6'h3f) begin
      low_cnt <= low_cnt + 6'h01;
    end
  end
  a_master_first: assert property ($rose(bus_master_oe) |-> !control_oe ##[1:2] control_oe)
    else $error("control outputs enabled with the master indicator");
  a_master_last: assert property ($fell(control_oe) |-> bus_master_oe ##[1:2] !bus_master_oe)
    else $error("master indicator not held after controls float");
  a_buf_quiet: assert property (single && control_oe |-> data_buffer_enable_n)
    else $error("buffer enable active in single mode");
  a_memory_only: assert property (single && control_oe |-> !address_is_peripheral)
    else $error("peripheral addressed in single mode");
  a_byte_lane: assert property (single && port_is_8bit && !ds_off |-> uds_n == !byte_odd && lds_n == byte_odd)
    else $error("wrong byte strobe for narrow port");
  a_wr_strobe_gap: assert property (single && !to_peripheral && $fell(ack_n) |-> ds_off[*3] ##[1:4] !ds_off)
    else $error("write strobes not one bus clock after acknowledge");
  a_rd_min_cycle: assert property (single && to_peripheral && $rose(as_n) |-> low_cnt >= 6'h0e)
    else $error("read cycle shorter than four bus clocks");
  a_wr_min_cycle: assert property (single && !to_peripheral && $rose(as_n) |-> low_cnt >= 6'h12)
    else $error("write cycle shorter than five bus clocks");
  a_dtc_on_dtack: assert property (single && !ack_n && $fell(dtack_n) |-> ##[0:2] !transfer_complete_strobe_n)
    else $error("complete strobe missing after memory acknowledge");
  a_ack_drops: assert property (single && as_n && ds_off |-> ack_n && transfer_complete_strobe_n)
    else $error("acknowledge outlives the bus cycle");
  a_addr_span: assert property ($rose(addr_low_valid) |-> addr_low_valid[*6] ##1 !addr_low_valid)
    else $error("low address not valid for three half clocks");
  cover property (single && !to_peripheral && !ds_off);
  cover property (peripheral_type_field == PTYPE_ECLOCK && !ack_n);
  cover property (operand_done && !single);
endmodule // dcp_channel_assertions
`default_nettype wire

// ### tb/dcp_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module dcp_mem_model
  import dcp_pkg::*;
#(
  parameter logic [DATA_WIDTH-1:0] WORD = 16'hc35a
)
(
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire logic                  slow,
  input  wire logic                  bus_request,
  input  wire logic                  bus_master_oe,
  input  wire logic                  as_n,
  input  wire logic                  uds_n,
  input  wire logic                  lds_n,
  output logic                       bus_grant,
  output logic                       dtack_n,
  output logic                       e_clock,
  output logic [DATA_WIDTH-1:0]      data_in
);
  logic [3:0]            wait_cnt;
  logic [3:0]            e_cnt;
  logic                  req_d;
  logic [DATA_WIDTH-1:0] noise;
  wire                   ds_on = !(uds_n && lds_n);
  wire [3:0]             lat   = slow ? 4'h6 : 4'h1;
  assign data_in = as_n ? noise : WORD;
  // Free running enable clock; the grant lingers so it cannot drop mid-handover
  always_ff @(posedge clock) begin
    if (reset) begin
      {req_d, bus_grant, e_clock} <= 3'h0;
      {wait_cnt, e_cnt} <= 8'h00;
      dtack_n <= 1'b1;
      noise <= 16'h0001;
    end else begin
      req_d <= bus_request;
      bus_grant <= bus_request || req_d || bus_master_oe;
      noise <= noise + 16'h1357;
      e_cnt <= (e_cnt == 4'h9) ? 4'h0 : e_cnt + 4'h1;
      e_clock <= (e_cnt == 4'h9) ? !e_clock : e_clock;
      wait_cnt <= ds_on ? wait_cnt + {3'h0, wait_cnt != 4'hf} : 4'h0;
      dtack_n <= !(ds_on && wait_cnt >= lat);
    end
  end
endmodule // dcp_mem_model
`default_nettype wire

// ### tb/dcp_channel_bench.sv
`timescale 1ns/10ps
`default_nettype none
module dcp_channel_bench
  import dcp_pkg::*;
;
  localparam logic [15:0] WORD = 16'hc35a;
  logic clock, reset, channel_enable, to_peripheral, port_is_8bit, byte_odd, request_n, slow;
  logic [1:0] request_generation_select, peripheral_type_field, operand_parts;
  logic bus_grant, dtack_n, peripheral_control_line, bus_request, bus_master_oe, control_oe;
  logic as_n, uds_n, lds_n, rw_n, address_is_peripheral, addr_low_valid, ack_n, data_oe;
  logic transfer_complete_strobe_n, data_buffer_direction, data_buffer_enable_n, operand_done;
  logic [DATA_WIDTH-1:0] data_in, data_out;
  int err_count, check_count, done_cnt, per_seen, hold_seen, ack_seen, dtc_seen, bad_seen;
  dcp_channel i_dcp_channel (.clock, .reset, .channel_enable, .request_generation_select,
    .peripheral_type_field, .to_peripheral, .port_is_8bit, .byte_odd, .operand_parts, .request_n,
    .peripheral_control_line, .bus_grant, .dtack_n, .data_in, .bus_request, .bus_master_oe, .control_oe,
    .as_n, .uds_n, .lds_n, .rw_n, .address_is_peripheral, .addr_low_valid, .ack_n,
    .transfer_complete_strobe_n, .data_buffer_direction, .data_buffer_enable_n, .data_out, .data_oe,
    .operand_done);
  dcp_mem_model #(.WORD(WORD)) i_dcp_mem_model (.clock, .reset, .slow, .bus_request, .bus_master_oe,
    .as_n, .uds_n, .lds_n, .bus_grant, .dtack_n, .e_clock(peripheral_control_line), .data_in);
  initial begin
    clock = 1'b0;
    forever #2 clock = !clock;
  end
  always @(posedge clock) begin
    done_cnt += int'(operand_done === 1'b1);
    per_seen |= int'(control_oe === 1'b1 && address_is_peripheral === 1'b1);
    hold_seen |= int'(data_oe === 1'b1);
    ack_seen |= int'(ack_n === 1'b0);
    dtc_seen |= int'(transfer_complete_strobe_n === 1'b0);
    bad_seen |= int'(data_oe === 1'b1 && (uds_n & lds_n) === 1'b0 && data_out !== WORD);
    bad_seen |= int'(peripheral_type_field[1] && control_oe === 1'b1 && data_buffer_direction !== 1'b0);
    // single cycle reads memory toward the peripheral
    bad_seen |= int'(peripheral_type_field[1] && as_n === 1'b0 && rw_n !== to_peripheral);
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic setup(input logic [1:0] sel, input logic [1:0] ty, input logic dir, input logic [1:0] parts);
    @(negedge clock);
    channel_enable = 1'b0;
    repeat (250) @(negedge clock);
    {request_generation_select, peripheral_type_field, to_peripheral, operand_parts} = {sel, ty, dir, parts};
    {done_cnt, per_seen, hold_seen, ack_seen, dtc_seen, bad_seen} = '0;
    @(negedge clock);
    channel_enable = 1'b1;
  endtask
  task automatic req();
    @(negedge clock);
    request_n = 1'b0;
    repeat (3) @(negedge clock);
    request_n = 1'b1;
  endtask
  task automatic wait_n(input int n);
    for (int i = 0; i < 800 && done_cnt < n; i++) @(negedge clock);
    repeat (200) @(negedge clock);
  endtask
  task automatic t_types();
    for (int t = 0; t < 4; t++) begin
      setup(REQUEST_GENERATION_SELECT_EXTERNAL, 2'(t), 1'b0, 2'h1);
      req();
      wait_n(1);
      chk("operands", 16'h1, 16'(done_cnt));
      chk("peripheral addressed", 16'(t < 2), 16'(per_seen));
      chk("holding write", 16'(t < 2), 16'(hold_seen));
      chk("data word", 16'h0, 16'(bad_seen));
      if (t != 0) chk("acknowledge", 16'h1, 16'(ack_seen));
    end
  endtask
  task automatic t_single();
    port_is_8bit = 1'b1;
    for (int i = 0; i < 4; i++) begin
      {slow, byte_odd} = 2'(i);
      setup(REQUEST_GENERATION_SELECT_EXTERNAL, PTYPE_ACK, slow ^ byte_odd, 2'h1);
      req();
      wait_n(1);
      chk("operands", 16'h1, 16'(done_cnt));
      chk("complete strobe", 16'h1, 16'(dtc_seen));
      chk("buffer direction", 16'h0, 16'(bad_seen));
    end
    {port_is_8bit, slow} = 2'h0;
  endtask
  task automatic t_holdoff();
    setup(REQUEST_GENERATION_SELECT_EXTERNAL, PTYPE_ASYNC, 1'b1, 2'h2);
    req();
    for (int i = 0; i < 200 && as_n !== 1'b0; i++) @(negedge clock);
    req();
    wait_n(1);
    chk("ignored request", 16'h1, 16'(done_cnt));
  endtask
  task automatic t_select();
    setup(REQUEST_GENERATION_SELECT_MIXED, PTYPE_ACK, 1'b1, 2'h1);
    wait_n(1);
    chk("first auto", 16'h1, 16'(done_cnt));
    chk("acknowledge kept", 16'h1, 16'(ack_seen));
    req();
    wait_n(2);
    chk("then external", 16'h2, 16'(done_cnt));
    setup(REQUEST_GENERATION_SELECT_EXTERNAL, PTYPE_ACK, 1'b1, 2'h1);
    wait_n(1);
    chk("no request", 16'h0, 16'(done_cnt));
    for (int s = 0; s < 2; s++) begin
      setup(2'(s), PTYPE_ACK, 1'b1, 2'h1);
      wait_n(3);
      chk("auto runs", 16'h1, 16'(done_cnt >= 3));
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    {reset, channel_enable, request_n} = 3'h5;
    {to_peripheral, port_is_8bit, byte_odd, slow} = 4'h0;
    {request_generation_select, peripheral_type_field, operand_parts} = 6'h21;
    repeat (12) @(negedge clock);
    reset = 1'b0;
    t_types();
    t_single();
    t_holdoff();
    t_select();
    report_and_stop();
  end
  // Runs take under 18k clocks; this allows over five times that
  initial begin
    #400000;
    err_count++;
    report_and_stop();
  end
endmodule // dcp_channel_bench
bind dcp_channel dcp_channel_assertions i_dcp_channel_assertions (.clock, .reset, .peripheral_type_field,
  .to_peripheral, .port_is_8bit, .byte_odd, .dtack_n, .bus_master_oe, .control_oe, .as_n, .uds_n, .lds_n,
  .address_is_peripheral, .addr_low_valid, .ack_n, .transfer_complete_strobe_n, .data_buffer_enable_n,
  .operand_done);
`default_nettype wire
